// [design/tsrh_pkg.sv]
// Constants and types shared by the trigger and system remote handler
package tsrh_pkg;
	localparam int DW = 16;
	localparam int IRQ_W = 5;
	// Register offsets
	localparam logic [7:0] OFS_LEVEL     = 8'h00;
	localparam logic [7:0] OFS_TRIG      = 8'h01;
	localparam logic [7:0] OFS_PRESET    = 8'h02;
	localparam logic [7:0] OFS_OPER_EN   = 8'h03;
	localparam logic [7:0] OFS_QUES_EN   = 8'h04;
	localparam logic [7:0] OFS_OPER_PTR  = 8'h05;
	localparam logic [7:0] OFS_OPER_NTR  = 8'h06;
	localparam logic [7:0] OFS_QUES_PTR  = 8'h07;
	localparam logic [7:0] OFS_QUES_NTR  = 8'h08;
	localparam logic [7:0] OFS_OPER_COND = 8'h09;
	localparam logic [7:0] OFS_QUES_COND = 8'h0A;
	localparam logic [7:0] OFS_ERR_STAT  = 8'h0B;
	localparam logic [7:0] OFS_ERR_SYS   = 8'h0C;
	localparam logic [7:0] OFS_BUS_ADDR  = 8'h0D;
	localparam logic [7:0] OFS_VERSION   = 8'h0E;
	localparam logic [7:0] OFS_SECURITY  = 8'h0F;
	localparam logic [7:0] OFS_PON_SLOT  = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h11;
	localparam logic [7:0] OFS_IRQ_CLR   = 8'h12;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h13;
	localparam logic [7:0] OFS_BUS_STATE = 8'h14;
	localparam logic [7:0] OFS_SW_TRIG   = 8'h15;
	// Field positions
	localparam int TRIG_SLOPE_BIT = 0;
	localparam int TRIG_SRC_LSB   = 1;
	localparam int TRIG_MODE_LSB  = 3;
	localparam int IRQ_TRIG   = 0;
	localparam int IRQ_DCLR   = 1;
	localparam int IRQ_LOCK   = 2;
	localparam int IRQ_ERR    = 3;
	localparam int IRQ_OFFBUS = 4;
	// Values
	localparam logic [15:0] PTR_PRESET  = 16'h7FFF;
	localparam logic [15:0] NTR_PRESET  = 16'h0000;
	localparam logic [15:0] EN_PRESET   = 16'h0000;
	localparam logic [15:0] VERSION_X10 = 16'h4DD0;
	localparam logic signed [15:0] LEVEL_MAX_MV = 16'sh2710;
	localparam logic signed [10:0] LEVEL_RST = 11'sh000;
	localparam logic [15:0] ERR_RANGE   = 16'hFF22;
	localparam logic [4:0]  ADDR_OFFBUS = 5'h1F;
	localparam logic [4:0]  ADDR_RST    = 5'h0A;
	localparam logic [6:0]  SLOT_MAX    = 7'h63;
	localparam logic [6:0]  SLOT_LAST   = 7'h63;
	localparam logic [6:0]  SLOT_RST    = 7'h00;
	// Bus command bytes
	localparam logic [7:0] CMD_GTL  = 8'h01;
	localparam logic [7:0] CMD_SDC  = 8'h04;
	localparam logic [7:0] CMD_GET  = 8'h08;
	localparam logic [7:0] CMD_LLO  = 8'h11;
	localparam logic [7:0] CMD_DCL  = 8'h14;
	localparam logic [7:0] CMD_LSN  = 8'h20;
	localparam logic [7:0] CMD_UNL  = 8'h3F;
	localparam logic [7:0] CMD_TLK  = 8'h40;
	localparam logic [7:0] CMD_UNT  = 8'h5F;
	typedef enum logic [1:0] {MODE_CONT, MODE_TRIG, MODE_GATE, MODE_BURST}
		tsrh_mode_type;
	typedef enum logic [1:0] {SRC_MAN, SRC_BUS, SRC_INT, SRC_EXT}
		tsrh_src_type;
endpackage

// [design/tsrh_errq_if.sv]
// Connection between the handler and its error queue
`timescale 1ns/1ps
`default_nettype none
interface tsrh_errq_if #(parameter int WIDTH = 16);
	logic             push;
	logic             pop;
	logic [WIDTH-1:0] push_data;
	logic [WIDTH-1:0] head;
	logic             empty;
	logic             full;
	modport owner (output push, pop, push_data, input head, empty, full);
	modport queue (input push, pop, push_data, output head, empty, full);
endinterface
`default_nettype wire

// [design/tsrh_errq.sv]
// Error queue held in flip-flops, oldest entry at the head
`timescale 1ns/1ps
`default_nettype none
module tsrh_errq #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic  clk_sys,
	input  wire logic  sys_rst,
	input  wire logic  ce,
	tsrh_errq_if.queue q
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0]    rd_reg, rd_next;
	logic [PW:0]      cnt_reg, cnt_next;
	logic             do_push, do_pop;

	always_comb begin
		do_pop = q.pop && (cnt_reg != '0);
		do_push = q.push && (!q.full || do_pop);
		mem_next = mem_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (do_push) begin
			mem_next[PW'(rd_reg + PW'(cnt_reg))] = q.push_data;
		end
		if (do_pop) begin
			rd_next = PW'(rd_reg + 1'b1);
		end
		cnt_next = cnt_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_reg <= '0;
			cnt_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (ce) begin
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			mem_reg <= mem_next;
		end
	end

	assign q.empty = (cnt_reg == '0);
	assign q.full = (cnt_reg == (PW+1)'(DEPTH));
	assign q.head = q.empty ? '0 : mem_reg[rd_reg];
endmodule // tsrh_errq
`default_nettype wire

// [design/tsrh_top.sv]
// Trigger settings, status, system settings and bus message handler
`timescale 1ns/1ps
`default_nettype none
module tsrh_top #(
	parameter int ERRQ_DEPTH = 8
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	input  wire logic        bus_cmd_valid,
	input  wire logic [7:0]  bus_cmd_byte,
	input  wire logic        ren_pin,
	input  wire logic        ext_trig_pin,
	input  wire logic        man_key,
	input  wire logic        int_tick,
	input  wire logic        panel_addr_wr,
	input  wire logic [4:0]  panel_addr,
	input  wire logic [6:0]  nv_pon_slot,
	output logic             trig_fire,
	output logic             dev_clear,
	output logic             panel_locked,
	output logic             remote,
	output logic             listener,
	output logic             talker,
	output logic             off_bus,
	output logic signed [10:0] trig_level,
	output logic             factory_reset,
	output logic             pon_load,
	output logic [6:0]       pon_slot,
	output logic             pon_restore_last,
	output logic             irq
);
	tsrh_errq_if #(.WIDTH(16)) eq ();
	tsrh_errq #(.WIDTH(16), .DEPTH(ERRQ_DEPTH)) u_errq (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.ce      (ce),
		.q       (eq)
	);

	// Round a signed mV value to 10 mV steps
	function automatic logic signed [10:0] rnd10(input logic signed [15:0] mv);
		logic [15:0] mag;
		logic [15:0] q;
		mag = mv[15] ? 16'(-mv) : 16'(mv);
		q = 16'((mag + 16'h0005) / 16'h000A);
		return mv[15] ? 11'(-$signed(q)) : 11'(q);
	endfunction
	// Round a value with one fractional bit to an integer
	function automatic logic [7:0] rnd_half(input logic [15:0] x);
		return 8'((x + 16'h0001) >> 1);
	endfunction

	localparam int IRQ_W_L = tsrh_pkg::IRQ_W;
	logic signed [10:0] level_reg, level_next;
	logic        slope_reg, slope_next;
	tsrh_pkg::tsrh_src_type  src_reg, src_next;
	tsrh_pkg::tsrh_mode_type mode_reg, mode_next;
	logic [15:0] oper_en_reg, oper_en_next, ques_en_reg, ques_en_next;
	logic [15:0] oper_ptr_reg, oper_ptr_next, oper_ntr_reg, oper_ntr_next;
	logic [15:0] ques_ptr_reg, ques_ptr_next, ques_ntr_reg, ques_ntr_next;
	logic [4:0]  addr_reg, addr_next;
	logic        sec_reg, sec_next;
	logic [6:0]  slot_reg, slot_next;
	logic        boot_reg, boot_next;
	logic        listen_reg, listen_next, talk_reg, talk_next;
	logic        remote_reg, remote_next, lock_reg, lock_next;
	logic [IRQ_W_L-1:0] ist_reg, ist_next, ien_reg, ien_next;
	logic        irq_reg, irq_next;
	logic        fire_reg, fire_next, dclr_reg, dclr_next;
	logic        fact_reg, fact_next, pload_reg, pload_next;
	logic        plast_reg, plast_next;
	logic [15:0] rdata_reg, rdata_next;
	logic [2:0]  ren_sync_reg, ren_sync_next, ext_sync_reg, ext_sync_next;
	logic        ren_filt_reg, ren_filt_next, ext_filt_reg, ext_filt_next;
	logic        offb_reg, offb_next;

	logic        offbus, wr_ok, cmd_ok, trig_armed, bus_trig, ext_edge;
	logic        range_err, sw_trig;
	logic [7:0]  rq;
	logic [IRQ_W_L-1:0] ev;

	always_comb begin
		ren_sync_next = {ren_sync_reg[1:0], ren_pin};
		ext_sync_next = {ext_sync_reg[1:0], ext_trig_pin};
		ren_filt_next = ren_filt_reg;
		ext_filt_next = ext_filt_reg;
		if (ren_sync_reg[1] == ren_sync_reg[2]) begin
			ren_filt_next = ren_sync_reg[2];
		end
		if (ext_sync_reg[1] == ext_sync_reg[2]) begin
			ext_filt_next = ext_sync_reg[2];
		end
		ext_edge = (ext_filt_next != ext_filt_reg) &&
			(ext_filt_next != slope_reg);
		offbus = (addr_reg == tsrh_pkg::ADDR_OFFBUS);
		wr_ok = reg_wr;
		cmd_ok = bus_cmd_valid && !offbus;
		trig_armed = (mode_reg != tsrh_pkg::MODE_CONT);
		range_err = 1'b0;
		sw_trig = 1'b0;
		level_next = level_reg;
		slope_next = slope_reg;
		src_next = src_reg;
		mode_next = mode_reg;
		oper_en_next = oper_en_reg;
		ques_en_next = ques_en_reg;
		oper_ptr_next = oper_ptr_reg;
		oper_ntr_next = oper_ntr_reg;
		ques_ptr_next = ques_ptr_reg;
		ques_ntr_next = ques_ntr_reg;
		addr_next = addr_reg;
		sec_next = sec_reg;
		slot_next = slot_reg;
		listen_next = listen_reg;
		talk_next = talk_reg;
		remote_next = remote_reg;
		lock_next = lock_reg;
		ien_next = ien_reg;
		dclr_next = 1'b0;
		fact_next = 1'b0;
		pload_next = 1'b0;
		plast_next = 1'b0;
		boot_next = 1'b0;
		bus_trig = 1'b0;
		rq = 8'h00;
		if (boot_reg) begin
			slot_next = (nv_pon_slot > tsrh_pkg::SLOT_MAX) ?
				tsrh_pkg::SLOT_MAX : nv_pon_slot;
			pload_next = 1'b1;
			plast_next = (slot_next == tsrh_pkg::SLOT_LAST);
		end
		if (wr_ok) begin
			unique case (reg_addr)
				tsrh_pkg::OFS_LEVEL: begin
					if ($signed(reg_wdata) > tsrh_pkg::LEVEL_MAX_MV ||
						$signed(reg_wdata) < -tsrh_pkg::LEVEL_MAX_MV) begin
						range_err = 1'b1;
					end else begin
						level_next = rnd10(reg_wdata);
					end
				end
				tsrh_pkg::OFS_TRIG: begin
					slope_next = reg_wdata[tsrh_pkg::TRIG_SLOPE_BIT];
					src_next = tsrh_pkg::tsrh_src_type'(
						reg_wdata[tsrh_pkg::TRIG_SRC_LSB +: 2]);
					mode_next = tsrh_pkg::tsrh_mode_type'(
						reg_wdata[tsrh_pkg::TRIG_MODE_LSB +: 2]);
				end
				tsrh_pkg::OFS_PRESET: begin
					oper_en_next = tsrh_pkg::EN_PRESET;
					ques_en_next = tsrh_pkg::EN_PRESET;
					oper_ptr_next = tsrh_pkg::PTR_PRESET;
					ques_ptr_next = tsrh_pkg::PTR_PRESET;
					oper_ntr_next = tsrh_pkg::NTR_PRESET;
					ques_ntr_next = tsrh_pkg::NTR_PRESET;
				end
				tsrh_pkg::OFS_OPER_EN:  oper_en_next = reg_wdata;
				tsrh_pkg::OFS_QUES_EN:  ques_en_next = reg_wdata;
				tsrh_pkg::OFS_OPER_PTR: oper_ptr_next = reg_wdata;
				tsrh_pkg::OFS_OPER_NTR: oper_ntr_next = reg_wdata;
				tsrh_pkg::OFS_QUES_PTR: ques_ptr_next = reg_wdata;
				tsrh_pkg::OFS_QUES_NTR: ques_ntr_next = reg_wdata;
				tsrh_pkg::OFS_BUS_ADDR: begin
					if (rnd_half(reg_wdata) > 8'(tsrh_pkg::ADDR_OFFBUS) ||
						reg_wdata[15:8] != 8'h00) begin
						range_err = 1'b1;
					end else if (!offbus) begin
						addr_next = 5'(rnd_half(reg_wdata));
					end
				end
				tsrh_pkg::OFS_SECURITY: begin
					sec_next = reg_wdata[0];
					if (sec_reg && !reg_wdata[0]) begin
						fact_next = 1'b1;
					end
				end
				tsrh_pkg::OFS_PON_SLOT: begin
					if (rnd_half(reg_wdata) > 8'(tsrh_pkg::SLOT_MAX) ||
						reg_wdata[15:8] != 8'h00) begin
						range_err = 1'b1;
					end else begin
						slot_next = 7'(rnd_half(reg_wdata));
					end
				end
				tsrh_pkg::OFS_IRQ_EN:  ien_next = reg_wdata[IRQ_W_L-1:0];
				tsrh_pkg::OFS_SW_TRIG: sw_trig = 1'b1;
				default: ;
			endcase
		end
		if (fact_next) begin
			level_next = tsrh_pkg::LEVEL_RST;
			slope_next = 1'b0;
			src_next = tsrh_pkg::SRC_MAN;
			mode_next = tsrh_pkg::MODE_CONT;
			slot_next = tsrh_pkg::SLOT_RST;
		end
		if (panel_addr_wr && panel_addr != tsrh_pkg::ADDR_OFFBUS) begin
			addr_next = panel_addr;
		end
		if (!ren_filt_reg) begin
			remote_next = 1'b0;
			lock_next = 1'b0;
		end else if (cmd_ok) begin
			if (bus_cmd_byte == (tsrh_pkg::CMD_LSN | 8'(addr_reg))) begin
				listen_next = 1'b1;
				remote_next = 1'b1;
			end else if (bus_cmd_byte == tsrh_pkg::CMD_UNL) begin
				listen_next = 1'b0;
			end else if (bus_cmd_byte == (tsrh_pkg::CMD_TLK | 8'(addr_reg))) begin
				talk_next = 1'b1;
			end else if (bus_cmd_byte == tsrh_pkg::CMD_UNT) begin
				talk_next = 1'b0;
			end else if (bus_cmd_byte == tsrh_pkg::CMD_DCL) begin
				dclr_next = 1'b1;
			end else if (bus_cmd_byte == tsrh_pkg::CMD_SDC && listen_reg) begin
				dclr_next = 1'b1;
			end else if (bus_cmd_byte == tsrh_pkg::CMD_LLO && listen_reg) begin
				lock_next = 1'b1;
				remote_next = 1'b1;
			end else if (bus_cmd_byte == tsrh_pkg::CMD_GTL && listen_reg) begin
				remote_next = 1'b0;
			end else if (bus_cmd_byte == tsrh_pkg::CMD_GET && listen_reg) begin
				bus_trig = 1'b1;
			end
		end
		if (addr_next == tsrh_pkg::ADDR_OFFBUS) begin
			listen_next = 1'b0;
			talk_next = 1'b0;
		end
		offb_next = (addr_next == tsrh_pkg::ADDR_OFFBUS);
		fire_next = 1'b0;
		unique case (src_reg)
			tsrh_pkg::SRC_MAN: fire_next = trig_armed && man_key;
			tsrh_pkg::SRC_BUS: fire_next = trig_armed && (bus_trig || sw_trig);
			tsrh_pkg::SRC_INT: fire_next = trig_armed && int_tick;
			tsrh_pkg::SRC_EXT: fire_next = trig_armed && ext_edge;
		endcase
		ev = '0;
		ev[tsrh_pkg::IRQ_TRIG] = fire_next;
		ev[tsrh_pkg::IRQ_DCLR] = dclr_next;
		ev[tsrh_pkg::IRQ_LOCK] = lock_next && !lock_reg;
		ev[tsrh_pkg::IRQ_ERR] = range_err;
		ev[tsrh_pkg::IRQ_OFFBUS] = !offbus &&
			(addr_next == tsrh_pkg::ADDR_OFFBUS);
		ist_next = ist_reg;
		if (wr_ok && reg_addr == tsrh_pkg::OFS_IRQ_CLR) begin
			ist_next = ist_reg & ~reg_wdata[IRQ_W_L-1:0];
		end
		ist_next = ist_next | ev;
		irq_next = |(ist_next & ien_next);
		rdata_next = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				tsrh_pkg::OFS_LEVEL:     rdata_next = 16'(level_reg);
				tsrh_pkg::OFS_TRIG:      rdata_next = {11'h000, mode_reg,
					src_reg, slope_reg};
				tsrh_pkg::OFS_OPER_EN:   rdata_next = oper_en_reg;
				tsrh_pkg::OFS_QUES_EN:   rdata_next = ques_en_reg;
				tsrh_pkg::OFS_OPER_PTR:  rdata_next = oper_ptr_reg;
				tsrh_pkg::OFS_OPER_NTR:  rdata_next = oper_ntr_reg;
				tsrh_pkg::OFS_QUES_PTR:  rdata_next = ques_ptr_reg;
				tsrh_pkg::OFS_QUES_NTR:  rdata_next = ques_ntr_reg;
				tsrh_pkg::OFS_OPER_COND: rdata_next = 16'h0000;
				tsrh_pkg::OFS_QUES_COND: rdata_next = 16'h0000;
				tsrh_pkg::OFS_ERR_STAT, tsrh_pkg::OFS_ERR_SYS: begin
					rdata_next = eq.head;
					rq = 8'h01;
				end
				tsrh_pkg::OFS_BUS_ADDR:  rdata_next = {11'h000, addr_reg};
				tsrh_pkg::OFS_VERSION:   rdata_next = tsrh_pkg::VERSION_X10;
				tsrh_pkg::OFS_SECURITY:  rdata_next = {15'h0000, sec_reg};
				tsrh_pkg::OFS_PON_SLOT:  rdata_next = {9'h000, slot_reg};
				tsrh_pkg::OFS_IRQ_STAT:  rdata_next = 16'(ist_reg);
				tsrh_pkg::OFS_IRQ_EN:    rdata_next = 16'(ien_reg);
				tsrh_pkg::OFS_BUS_STATE: rdata_next = {11'h000, offbus,
					lock_reg, remote_reg, talk_reg, listen_reg};
				default:                 rdata_next = 16'h0000;
			endcase
		end
	end

	assign eq.push = ce && range_err;
	assign eq.push_data = tsrh_pkg::ERR_RANGE;
	assign eq.pop = ce && rq[0];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			level_reg <= tsrh_pkg::LEVEL_RST;
			slope_reg <= 1'b0;
			src_reg <= tsrh_pkg::SRC_MAN;
			mode_reg <= tsrh_pkg::MODE_CONT;
			oper_en_reg <= tsrh_pkg::EN_PRESET;
			ques_en_reg <= tsrh_pkg::EN_PRESET;
			oper_ptr_reg <= tsrh_pkg::PTR_PRESET;
			oper_ntr_reg <= tsrh_pkg::NTR_PRESET;
			ques_ptr_reg <= tsrh_pkg::PTR_PRESET;
			ques_ntr_reg <= tsrh_pkg::NTR_PRESET;
			addr_reg <= tsrh_pkg::ADDR_RST;
			sec_reg <= 1'b0;
			slot_reg <= tsrh_pkg::SLOT_RST;
			boot_reg <= 1'b1;
			{listen_reg, talk_reg, remote_reg, lock_reg} <= 4'h0;
			ist_reg <= '0;
			ien_reg <= '0;
			{irq_reg, fire_reg, dclr_reg, fact_reg} <= 4'h0;
			{pload_reg, plast_reg} <= 2'h0;
			rdata_reg <= 16'h0000;
			ren_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
			ren_filt_reg <= 1'b0;
			ext_filt_reg <= 1'b0;
			offb_reg <= 1'b0;
		end else if (ce) begin
			level_reg <= level_next;
			slope_reg <= slope_next;
			src_reg <= src_next;
			mode_reg <= mode_next;
			oper_en_reg <= oper_en_next;
			ques_en_reg <= ques_en_next;
			oper_ptr_reg <= oper_ptr_next;
			oper_ntr_reg <= oper_ntr_next;
			ques_ptr_reg <= ques_ptr_next;
			ques_ntr_reg <= ques_ntr_next;
			addr_reg <= addr_next;
			sec_reg <= sec_next;
			slot_reg <= slot_next;
			boot_reg <= boot_next;
			{listen_reg, talk_reg} <= {listen_next, talk_next};
			{remote_reg, lock_reg} <= {remote_next, lock_next};
			ist_reg <= ist_next;
			ien_reg <= ien_next;
			{irq_reg, fire_reg, dclr_reg, fact_reg} <=
				{irq_next, fire_next, dclr_next, fact_next};
			{pload_reg, plast_reg} <= {pload_next, plast_next};
			rdata_reg <= rdata_next;
			ren_sync_reg <= ren_sync_next;
			ext_sync_reg <= ext_sync_next;
			ren_filt_reg <= ren_filt_next;
			ext_filt_reg <= ext_filt_next;
			offb_reg <= offb_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign trig_fire = fire_reg;
	assign dev_clear = dclr_reg;
	assign panel_locked = lock_reg;
	assign remote = remote_reg;
	assign listener = listen_reg;
	assign talker = talk_reg;
	assign off_bus = offb_reg;
	assign trig_level = level_reg;
	assign factory_reset = fact_reg;
	assign pon_load = pload_reg;
	assign pon_slot = slot_reg;
	assign pon_restore_last = plast_reg;
	assign irq = irq_reg;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	preset_filters_a: assert property (
		ce && reg_wr && reg_addr == tsrh_pkg::OFS_PRESET |=>
		oper_ptr_reg == tsrh_pkg::PTR_PRESET && ques_ntr_reg == 16'h0000 &&
		oper_en_reg == 16'h0000 && ques_en_reg == 16'h0000)
		else $error("status preset did not load filters");
	cond_zero_a: assert property (
		ce && reg_rd && reg_addr == tsrh_pkg::OFS_QUES_COND |=>
		reg_rdata == 16'h0000)
		else $error("condition register not zero");
	offbus_quiet_a: assert property (
		off_bus |=> !listener && !talker && !dev_clear)
		else $error("off-bus device reacted to bus");
	addr_hold_a: assert property (
		off_bus && !panel_addr_wr |=> off_bus)
		else $error("off-bus left without front panel");
	version_a: assert property (
		ce && reg_rd && reg_addr == tsrh_pkg::OFS_VERSION |=>
		reg_rdata == 16'h4DD0)
		else $error("version reply wrong");
	sec_erase_a: assert property (
		ce && reg_wr && reg_addr == tsrh_pkg::OFS_SECURITY && sec_reg &&
		!reg_wdata[0] |=> factory_reset && trig_level == 11'sh000)
		else $error("security off did not erase");
	get_fire_a: assert property (
		ce && cmd_ok && ren_filt_reg && bus_cmd_byte == 8'h08 && listen_reg &&
		src_reg == tsrh_pkg::SRC_BUS && trig_armed |=> trig_fire)
		else $error("bus trigger did not fire");
	sdc_listen_a: assert property (
		ce && cmd_ok && bus_cmd_byte == 8'h04 && !listen_reg |=> !dev_clear)
		else $error("selected clear taken while not listener");
	lockout_a: assert property (
		$rose(panel_locked) |-> $past(listen_reg) && $past(ren_filt_reg))
		else $error("lockout without listen and remote enable");
	slope_a: assert property (
		ce && src_reg == tsrh_pkg::SRC_EXT && trig_armed &&
		ext_filt_next != ext_filt_reg |=>
		trig_fire == (ext_filt_reg != $past(slope_reg)))
		else $error("trigger on wrong edge");
endmodule // tsrh_top
`default_nettype wire

// [verification/tsrh_ctrl_model.sv]
// Bus controller model that sends command bytes to the handler
`timescale 1ns/1ps
`default_nettype none
module tsrh_ctrl_model (
	input  wire logic  clk_sys,
	output logic       cmd_valid,
	output logic [7:0] cmd_byte,
	output logic       ren
);
	initial begin
		cmd_valid = 1'b0;
		cmd_byte  = 8'h00;
		ren       = 1'b0;
	end
	// Idle byte is the inverse of the last one, never a stale copy
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_byte  <= b;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		cmd_byte  <= ~b;
	endtask
	// Remote enable and listen addressing come before lockout
	task automatic lockout(input logic [4:0] a);
		@(posedge clk_sys);
		ren <= 1'b1;
		repeat (4) @(posedge clk_sys);
		send(tsrh_pkg::CMD_LSN + {3'b000, a});
		send(tsrh_pkg::CMD_LLO);
	endtask
endmodule // tsrh_ctrl_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the trigger and system remote handler
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic               clk_sys, reg_wr, reg_rd, ext_pin, pan_wr, bus_v;
	logic               sys_rst = 1'b1;
	logic [7:0]         reg_addr, bus_b;
	logic [15:0]        reg_wdata, reg_rdata, d;
	logic [6:0]         nv_slot = 7'h00;
	logic [6:0]         pon_slot;
	logic [4:0]         pan_addr;
	logic               ren, fire, dclr, lock, rmt, lsn, tlk, offb, fac;
	logic               pon, last, irq, man_k, tick;
	logic signed [10:0] lvl_o;
	logic [15:0]        pre_exp [6] = '{16'h0000, 16'h0000, 16'h7FFF,
		16'h0000, 16'h7FFF, 16'h0000};
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int n_fire = 0, n_clr = 0, n_fac = 0, n_pon = 0, n_last = 0;
	int seed, v;
	tsrh_top uut (.clk_sys, .sys_rst, .ce(1'b1), .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .bus_cmd_valid(bus_v),
		.bus_cmd_byte(bus_b), .ren_pin(ren), .ext_trig_pin(ext_pin),
		.man_key(man_k), .int_tick(tick), .panel_addr_wr(pan_wr),
		.panel_addr(pan_addr), .nv_pon_slot(nv_slot), .trig_fire(fire),
		.dev_clear(dclr), .panel_locked(lock), .remote(rmt),
		.listener(lsn), .talker(tlk), .off_bus(offb), .trig_level(lvl_o),
		.factory_reset(fac), .pon_load(pon), .pon_slot,
		.pon_restore_last(last), .irq);
	tsrh_ctrl_model ctrl (.clk_sys, .cmd_valid(bus_v), .cmd_byte(bus_b),
		.ren(ren));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (!sys_rst) begin
			n_fire += int'(fire === 1'b1);
			n_clr  += int'(dclr === 1'b1);
			n_fac  += int'(fac === 1'b1);
			n_pon  += int'(pon === 1'b1);
			n_last += int'(last === 1'b1);
		end
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	function automatic logic [15:0] lvl_exp(input int mv);
		return 16'((mv + (mv < 0 ? -5 : 5)) / 10);
	endfunction
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= w;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rst(input logic [6:0] s);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		nv_slot <= s;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		wt(3);
	endtask
	task automatic pin_to(input logic b);
		@(posedge clk_sys);
		ext_pin <= b;
		wt(8);
	endtask
	task automatic pulse(input logic [1:0] k);
		@(posedge clk_sys);
		{man_k, tick} <= k;
		@(posedge clk_sys);
		{man_k, tick} <= 2'b00;
		wt(2);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		seed = 32'h4fe6_a101;
		{reg_wr, reg_rd, ext_pin, pan_wr, man_k, tick} = 6'h00;
		reg_addr  = 8'h00;
		reg_wdata = 16'h0000;
		pan_addr  = 5'h00;
		rst(7'h63);
		chk("restore last", 16'd1, 16'(n_last));
		rst(7'h05);
		chk("pon load", 16'd2, 16'(n_pon));
		chk("pon slot", 16'h0005, {9'd0, pon_slot});
		chk("restore once", 16'd1, 16'(n_last));
		rd(tsrh_pkg::OFS_VERSION);
		chk("version", tsrh_pkg::VERSION_X10, d);
		v = $random(seed);
		wr(tsrh_pkg::OFS_OPER_EN, 16'(v));
		wr(tsrh_pkg::OFS_QUES_PTR, 16'(v));
		wr(tsrh_pkg::OFS_PRESET, 16'h0000);
		foreach (pre_exp[i]) begin
			rd(tsrh_pkg::OFS_OPER_EN + 8'(i));
			chk("preset", pre_exp[i], d);
		end
		rd(tsrh_pkg::OFS_QUES_COND);
		chk("condition", 16'h0000, d);
		wr(8'h7E, 16'hFFFF);
		rd(8'h7E);
		chk("unmapped", 16'h0000, d);
		for (int i = 0; i < 7; i++) begin
			v = (i == 0) ? 10000 : (i == 1) ? -10000 : (i == 2) ? 0 :
				$random(seed) % 10000;
			if (v % 10 == 5 || v % 10 == -5)
				v = v + 1;
			wr(tsrh_pkg::OFS_LEVEL, 16'(v));
			rd(tsrh_pkg::OFS_LEVEL);
			chk("level", lvl_exp(v), d);
			chk("level out", lvl_exp(v), 16'(lvl_o));
		end
		wr(tsrh_pkg::OFS_IRQ_EN, 16'h0008);
		wr(tsrh_pkg::OFS_LEVEL, 16'd10001);
		wr(tsrh_pkg::OFS_BUS_ADDR, 16'd64);
		wt(2);
		chk("irq set", 16'd1, 16'(irq));
		rd(tsrh_pkg::OFS_ERR_STAT);
		chk("error one", tsrh_pkg::ERR_RANGE, d);
		rd(tsrh_pkg::OFS_ERR_SYS);
		chk("error two", tsrh_pkg::ERR_RANGE, d);
		rd(tsrh_pkg::OFS_ERR_STAT);
		chk("error empty", 16'h0000, d);
		wr(tsrh_pkg::OFS_IRQ_CLR, 16'h0008);
		wt(2);
		chk("irq clear", 16'd0, 16'(irq));
		wr(tsrh_pkg::OFS_BUS_ADDR, 16'd39);
		rd(tsrh_pkg::OFS_BUS_ADDR);
		chk("address", 16'd20, d);
		wr(tsrh_pkg::OFS_TRIG, 16'h000A);
		ctrl.lockout(5'd20);
		wt(2);
		chk("listener", 16'd1, 16'(lsn));
		chk("locked", 16'd1, 16'(lock));
		ctrl.send(tsrh_pkg::CMD_GET);
		ctrl.send(tsrh_pkg::CMD_SDC);
		ctrl.send(tsrh_pkg::CMD_UNL);
		ctrl.send(tsrh_pkg::CMD_SDC);
		ctrl.send(tsrh_pkg::CMD_DCL);
		ctrl.send(tsrh_pkg::CMD_TLK + 8'd20);
		ctrl.send(tsrh_pkg::CMD_LSN + 8'd20);
		ctrl.send(tsrh_pkg::CMD_GTL);
		wt(2);
		chk("fires", 16'd1, 16'(n_fire));
		chk("clears", 16'd2, 16'(n_clr));
		chk("talker", 16'd1, 16'(tlk));
		chk("local", 16'd0, 16'(rmt));
		wr(tsrh_pkg::OFS_TRIG, 16'h001F);
		pin_to(1'b1);
		pin_to(1'b0);
		chk("falling", 16'd2, 16'(n_fire));
		wr(tsrh_pkg::OFS_TRIG, 16'h001E);
		pin_to(1'b1);
		chk("rising", 16'd3, 16'(n_fire));
		wr(tsrh_pkg::OFS_TRIG, 16'h0008);
		pulse(2'b10);
		wr(tsrh_pkg::OFS_TRIG, 16'h000C);
		pulse(2'b01);
		chk("man and timer", 16'd5, 16'(n_fire));
		wr(tsrh_pkg::OFS_TRIG, 16'h0004);
		pulse(2'b01);
		chk("continuous", 16'd5, 16'(n_fire));
		ctrl.send(tsrh_pkg::CMD_UNL);
		wr(tsrh_pkg::OFS_BUS_ADDR, 16'd62);
		ctrl.send(tsrh_pkg::CMD_LSN + 8'd20);
		wt(2);
		chk("off bus", 16'd1, 16'(offb));
		chk("deaf", 16'd0, 16'(lsn));
		wr(tsrh_pkg::OFS_BUS_ADDR, 16'd20);
		wt(2);
		chk("stays off", 16'd1, 16'(offb));
		@(posedge clk_sys);
		pan_wr   <= 1'b1;
		pan_addr <= 5'd5;
		@(posedge clk_sys);
		pan_wr <= 1'b0;
		wt(2);
		chk("panel", 16'd0, 16'(offb));
		wr(tsrh_pkg::OFS_SECURITY, 16'h0001);
		wr(tsrh_pkg::OFS_SECURITY, 16'h0000);
		wt(2);
		chk("erase", 16'd1, 16'(n_fac));
		close_out();
	end
endmodule // tb
`default_nettype wire
